// >>> common/abc_pkg.sv
/*
  Package of the block cipher coprocessor: register indices, field layout,
  reset values, cipher constants, state encoding and the packed state record.
  Assumes one clock domain and an APB master with 32-bit data.
*/
package abc_pkg;

  // ------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [9:0] IDX_CS     = 10'h0e8;
  localparam logic [9:0] IDX_KEY    = 10'h0f1;
  localparam logic [9:0] IDX_IV     = 10'h0f2;
  localparam logic [9:0] IDX_DATA   = 10'h0f3;
  localparam logic [9:0] IDX_KVPTR  = 10'h0f5;
  localparam logic [9:0] IDX_DPTR   = 10'h0f6;

  // ------------------------------------------------------------------
  // Control field layout and mode codes
  // ------------------------------------------------------------------
  localparam int         CS_GO_BIT   = 0;
  localparam int         CS_DECR_BIT = 1;
  localparam int         CS_MODE_LSB = 2;
  localparam int         CS_MODE_MSB = 4;
  localparam int         KPTR_LSB    = 4;
  localparam int         PTR_W       = 4;
  localparam logic [2:0] MODE_CBC    = 3'h0;
  localparam logic [2:0] MODE_CFB    = 3'h1;
  localparam logic [2:0] MODE_OFB    = 3'h2;
  localparam logic [2:0] MODE_CTR    = 3'h3;
  localparam logic [2:0] MODE_ECB    = 3'h4;
  localparam logic [2:0] MODE_RESET  = 3'h0;
  localparam logic [3:0] PTR_RESET   = 4'h0;
  localparam logic [3:0] PTR_STEP    = 4'h1;

  // ------------------------------------------------------------------
  // Cipher constants and timing
  // ------------------------------------------------------------------
  localparam logic [7:0]  AES_POLY    = 8'h1b;
  localparam logic [7:0]  SBOX_C      = 8'h63;
  localparam logic [7:0]  ISBOX_C     = 8'h05;
  localparam logic [7:0]  RCON_FIRST  = 8'h01;
  localparam logic [7:0]  RCON_LAST   = 8'h36;
  localparam logic [7:0]  RCON_WRAP   = 8'h80;
  localparam logic [31:0] MIX_FWD     = 32'h02030101;
  localparam logic [31:0] MIX_INV     = 32'h0e0b0d09;
  localparam logic [3:0]  LAST_ROUND  = 4'h9;
  localparam logic [5:0]  OP_CYCLES   = 6'h2d;
  localparam logic [5:0]  OP_LAST     = OP_CYCLES - 6'h01;

  typedef enum logic [2:0] {
    ABC_IDLE, ABC_START, ABC_KEXP, ABC_ENC, ABC_DEC, ABC_WAIT
  } abc_fsm_t;

  typedef struct packed {
    abc_fsm_t      fsm;
    logic          go;
    logic          decr;
    logic [2:0]    mode;
    logic [3:0]    key_byte_pointer;
    logic [3:0]    vector_byte_pointer;
    logic [3:0]    block_byte_pointer;
    logic [127:0]  key;
    logic [127:0]  iv;
    logic [127:0]  block_input;
    logic [127:0]  chain;
    logic [127:0]  ctr;
    logic [127:0]  s;
    logic [127:0]  rk;
    logic [7:0]    rc;
    logic [3:0]    rnd;
    logic [5:0]    cnt;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          irq;
  } abc_state_t;

endpackage : abc_pkg

// >>> rtl/abc_aes_block_coprocessor.sv
/*
  AES-128 block coprocessor with an APB register slave: byte-wide key,
  vector and data ports with auto-incrementing pointers, five chaining modes.
  Assumes an APB master on ref_clk and that software loads the operands
  before it sets the start bit.
*/
`timescale 1ns/1ns

// Notes on behaviour
// - Control bits 4:2 pick CBC, CFB, OFB, CTR or ECB chaining.
// - Control bit 1 low encrypts, high decrypts.
// - Writing one to bit 0 starts; it reads one until hardware finishes.
// - Each operation completes 45 clock cycles after start.
// - On completion an interrupt pulses and the result sits in the data port.
// - A 128-bit block is transformed under a 128-bit key, optional 128-bit vector.
// - ECB maps input to output directly; decryption starts from the last round key.
// - CBC XORs the previous result with incoming data; vector seeds the first.
// - CFB feeds cipher output back as next input, seeded by the vector.
// - OFB feeds cipher output back to the core, seeded by the vector.
// - CTR encrypts a counter loaded from the vector on entering the mode.
// - The counter reloads only when the mode selection changes.
// - Each 128-bit operand moves through one byte port in sixteen accesses.
// - A full transfer starts at the last byte position and works back.
// - Key and vector port accesses step a 4-bit pointer that wraps after sixteen.
// - Pointer n addresses row n mod 4, column n div 4, counted from the end.
// - Pointer register holds key pointer in 7:4, vector pointer in 3:0.
// - Data pointer register holds the data port pointer in 3:0.
// - Software may reposition a pointer and update a shorter run of bytes.
module abc_aes_block_coprocessor
  import abc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             cipher_done_irq
);

  // ------------------------------------------------------------------
  // Cipher arithmetic
  // ------------------------------------------------------------------
  function automatic logic [7:0] xt(input logic [7:0] b);
    return {b[6:0], 1'b0} ^ (b[7] ? AES_POLY : 8'h00);
  endfunction : xt

  function automatic logic [7:0] ixt(input logic [7:0] b);
    return (b == AES_POLY) ? RCON_WRAP : {1'b0, b[7:1]};
  endfunction : ixt

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        p = p ^ x;
      end
      x = xt(x);
    end
    return p;
  endfunction : gmul

  // Field inverse as x^254; avoids a 256-entry table per byte lane.
  function automatic logic [7:0] ginv(input logic [7:0] x);
    logic [7:0] r;
    logic [7:0] sq;
    r  = 8'h01;
    sq = x;
    for (int i = 1; i < 8; i++) begin
      sq = gmul(sq, sq);
      r  = gmul(r, sq);
    end
    return r;
  endfunction : ginv

  function automatic logic [7:0] rl(input logic [7:0] b, input int n);
    logic [15:0] d;
    d = {b, b} << n;
    return d[15:8];
  endfunction : rl

  function automatic logic [7:0] sb(input logic [7:0] x);
    logic [7:0] y;
    y = ginv(x);
    return y ^ rl(y, 1) ^ rl(y, 2) ^ rl(y, 3) ^ rl(y, 4) ^ SBOX_C;
  endfunction : sb

  function automatic logic [7:0] isb(input logic [7:0] x);
    return ginv(rl(x, 1) ^ rl(x, 3) ^ rl(x, 6) ^ ISBOX_C);
  endfunction : isb

  // Byte k of a block sits at bits 127-8k; byte (row i, column j) is k = i + 4j.
  function automatic logic [127:0] subshift(input logic [127:0] s, input logic inv);
    logic [127:0] o;
    logic [7:0]   b;
    int           sc;
    o  = '0;
    b  = 8'h00;
    sc = 0;
    for (int k = 0; k < 16; k++) begin
      sc = inv ? ((k / 4) + 4 - (k % 4)) % 4 : ((k / 4) + (k % 4)) % 4;
      b  = s[127 - 8 * ((k % 4) + 4 * sc) -: 8];
      o[127 - 8 * k -: 8] = inv ? isb(b) : sb(b);
    end
    return o;
  endfunction : subshift

  function automatic logic [127:0] mix(input logic [127:0] s, input logic inv);
    logic [127:0] o;
    logic [31:0]  cf;
    logic [7:0]   acc;
    o   = '0;
    cf  = inv ? MIX_INV : MIX_FWD;
    acc = 8'h00;
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 4; i++) begin
        acc = 8'h00;
        for (int j = 0; j < 4; j++) begin
          acc = acc ^ gmul(s[127 - 8 * (4 * c + (i + j) % 4) -: 8], cf[31 - 8 * j -: 8]);
        end
        o[127 - 8 * (4 * c + i) -: 8] = acc;
      end
    end
    return o;
  endfunction : mix

  function automatic logic [31:0] subrot(input logic [31:0] w, input logic [7:0] rc);
    return {sb(w[23:16]) ^ rc, sb(w[15:8]), sb(w[7:0]), sb(w[31:24])};
  endfunction : subrot

  function automatic logic [127:0] knext(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] n0;
    logic [31:0] n1;
    logic [31:0] n2;
    n0 = k[127:96] ^ subrot(k[31:0], rc);
    n1 = k[95:64] ^ n0;
    n2 = k[63:32] ^ n1;
    return {n0, n1, n2, k[31:0] ^ n2};
  endfunction : knext

  function automatic logic [127:0] kprev(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] p3;
    p3 = k[31:0] ^ k[63:32];
    return {k[127:96] ^ subrot(p3, rc), k[95:64] ^ k[127:96], k[63:32] ^ k[95:64], p3};
  endfunction : kprev

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  abc_state_t r_reg;
  abc_state_t r_next;

  logic [9:0]   idx;
  logic         hit;
  logic         cbc;
  logic         stream;
  logic         inv;
  logic [127:0] cin;
  logic [127:0] out;
  logic [127:0] tmp;
  logic [127:0] nk;
  logic [7:0]   rd;

  assign idx = paddr[11:2];
  // Codes above ECB are unassigned and behave as ECB.
  assign cbc    = (r_reg.mode == MODE_CBC);
  assign stream = (r_reg.mode == MODE_CFB) || (r_reg.mode == MODE_OFB)
                  || (r_reg.mode == MODE_CTR);
  // Only the block modes run the inverse cipher; stream modes always encrypt.
  assign inv    = r_reg.decr && !stream;

  always_comb begin
    r_next  = r_reg;
    hit     = 1'b0;
    rd      = 8'h00;
    cin     = '0;
    out     = '0;
    tmp     = '0;
    nk      = '0;
    r_next.irq     = 1'b0;
    r_next.pready  = 1'b0;
    r_next.pslverr = 1'b0;

    // ----------------------------------------------------------------
    // APB slave: one wait state, then pready for one cycle
    // ----------------------------------------------------------------
    hit = (paddr[1:0] == 2'b00) && ((idx == IDX_CS) || (idx == IDX_KEY)
          || (idx == IDX_IV) || (idx == IDX_DATA) || (idx == IDX_KVPTR)
          || (idx == IDX_DPTR));
    case (idx)
      IDX_CS:    rd = {3'b000, r_reg.mode, r_reg.decr, r_reg.go};
      IDX_KEY:   rd = r_reg.key[8 * r_reg.key_byte_pointer +: 8];
      IDX_IV:    rd = r_reg.iv[8 * r_reg.vector_byte_pointer +: 8];
      IDX_DATA:  rd = r_reg.block_input[8 * r_reg.block_byte_pointer +: 8];
      IDX_KVPTR: rd = {r_reg.key_byte_pointer, r_reg.vector_byte_pointer};
      IDX_DPTR:  rd = {4'h0, r_reg.block_byte_pointer};
      default:   rd = 8'h00;
    endcase
    if (psel && penable && !r_reg.pready) begin
      r_next.pready  = 1'b1;
      r_next.pslverr = !hit;
      r_next.prdata  = (hit && !pwrite) ? {24'h000000, rd} : 32'h00000000;
    end

    if (psel && penable && r_reg.pready && hit) begin
      case (idx)
        IDX_CS: begin
          if (pwrite && !r_reg.go) begin
            r_next.decr = pwdata[CS_DECR_BIT];
            r_next.mode = pwdata[CS_MODE_MSB:CS_MODE_LSB];
            if (pwdata[CS_MODE_MSB:CS_MODE_LSB] != r_reg.mode) begin
              r_next.ctr   = r_reg.iv;
              r_next.chain = r_reg.iv;
            end
            if (pwdata[CS_GO_BIT]) begin
              r_next.go  = 1'b1;
              r_next.fsm = ABC_START;
              r_next.cnt = 6'h00;
            end
          end
        end
        IDX_KEY: begin
          if (!pwrite || !r_reg.go) begin
            if (pwrite) begin
              r_next.key[8 * r_reg.key_byte_pointer +: 8] = pwdata[7:0];
            end
            r_next.key_byte_pointer = r_reg.key_byte_pointer + PTR_STEP;
          end
        end
        IDX_IV: begin
          if (!pwrite || !r_reg.go) begin
            if (pwrite) begin
              r_next.iv[8 * r_reg.vector_byte_pointer +: 8] = pwdata[7:0];
              // The vector stands in for the previous result on the next block.
              r_next.chain = r_next.iv;
            end
            r_next.vector_byte_pointer = r_reg.vector_byte_pointer + PTR_STEP;
          end
        end
        IDX_DATA: begin
          if (!pwrite || !r_reg.go) begin
            if (pwrite) begin
              r_next.block_input[8 * r_reg.block_byte_pointer +: 8] = pwdata[7:0];
            end
            r_next.block_byte_pointer = r_reg.block_byte_pointer + PTR_STEP;
          end
        end
        IDX_KVPTR: begin
          if (pwrite) begin
            r_next.key_byte_pointer    = pwdata[KPTR_LSB +: PTR_W];
            r_next.vector_byte_pointer = pwdata[PTR_W - 1:0];
          end
        end
        IDX_DPTR: begin
          if (pwrite) begin
            r_next.block_byte_pointer = pwdata[PTR_W - 1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Cipher sequencer: one round per cycle, padded to a fixed latency
    // ----------------------------------------------------------------
    if (r_reg.fsm != ABC_IDLE) begin
      r_next.cnt = r_reg.cnt + 6'h01;
    end
    case (r_reg.fsm)
      ABC_IDLE: begin
      end
      ABC_START: begin
        if (cbc && !r_reg.decr) begin
          cin = r_reg.block_input ^ r_reg.chain;
        end else if (r_reg.mode == MODE_CTR) begin
          cin = r_reg.ctr;
        end else if (stream) begin
          cin = r_reg.chain;
        end else begin
          cin = r_reg.block_input;
        end
        r_next.rk  = r_reg.key;
        r_next.rc  = RCON_FIRST;
        r_next.rnd = 4'h0;
        r_next.s   = inv ? cin : cin ^ r_reg.key;
        r_next.fsm = inv ? ABC_KEXP : ABC_ENC;
      end
      ABC_KEXP: begin
        // Decryption first walks the schedule forward to the last round key.
        nk = knext(r_reg.rk, r_reg.rc);
        r_next.rk  = nk;
        r_next.rc  = xt(r_reg.rc);
        r_next.rnd = r_reg.rnd + 4'h1;
        if (r_reg.rnd == LAST_ROUND) begin
          r_next.s   = r_reg.s ^ nk;
          r_next.rc  = RCON_LAST;
          r_next.rnd = 4'h0;
          r_next.fsm = ABC_DEC;
        end
      end
      ABC_ENC: begin
        nk  = knext(r_reg.rk, r_reg.rc);
        tmp = subshift(r_reg.s, 1'b0);
        if (r_reg.rnd != LAST_ROUND) begin
          tmp = mix(tmp, 1'b0);
        end
        r_next.s   = tmp ^ nk;
        r_next.rk  = nk;
        r_next.rc  = xt(r_reg.rc);
        r_next.rnd = r_reg.rnd + 4'h1;
        if (r_reg.rnd == LAST_ROUND) begin
          r_next.fsm = ABC_WAIT;
        end
      end
      ABC_DEC: begin
        nk  = kprev(r_reg.rk, r_reg.rc);
        tmp = subshift(r_reg.s, 1'b1) ^ nk;
        if (r_reg.rnd != LAST_ROUND) begin
          tmp = mix(tmp, 1'b1);
        end
        r_next.s   = tmp;
        r_next.rk  = nk;
        r_next.rc  = ixt(r_reg.rc);
        r_next.rnd = r_reg.rnd + 4'h1;
        if (r_reg.rnd == LAST_ROUND) begin
          r_next.fsm = ABC_WAIT;
        end
      end
      ABC_WAIT: begin
        if (r_reg.cnt == OP_LAST) begin
          if (cbc && r_reg.decr) begin
            out          = r_reg.s ^ r_reg.chain;
            r_next.chain = r_reg.block_input;
          end else if (cbc) begin
            out          = r_reg.s;
            r_next.chain = r_reg.s;
          end else if (r_reg.mode == MODE_CFB) begin
            out          = r_reg.block_input ^ r_reg.s;
            r_next.chain = r_reg.decr ? r_reg.block_input : out;
          end else if (r_reg.mode == MODE_OFB) begin
            out          = r_reg.block_input ^ r_reg.s;
            r_next.chain = r_reg.s;
          end else if (r_reg.mode == MODE_CTR) begin
            out        = r_reg.block_input ^ r_reg.s;
            r_next.ctr = r_reg.ctr + 128'h1;
          end else begin
            out = r_reg.s;
          end
          r_next.block_input = out;
          r_next.go          = 1'b0;
          r_next.irq         = 1'b1;
          r_next.fsm         = ABC_IDLE;
        end
      end
      default: begin
        r_next.fsm = ABC_IDLE;
        r_next.go  = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      r_reg                     <= '0;
      r_reg.fsm                 <= ABC_IDLE;
      r_reg.mode                <= MODE_RESET;
      r_reg.key_byte_pointer    <= PTR_RESET;
      r_reg.vector_byte_pointer <= PTR_RESET;
      r_reg.block_byte_pointer  <= PTR_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata          = r_reg.prdata;
  assign pready          = r_reg.pready;
  assign pslverr         = r_reg.pslverr;
  assign cipher_done_irq = r_reg.irq;

endmodule : abc_aes_block_coprocessor

// >>> sim/abc_sva.sv
/*
  Checker of the block cipher coprocessor: APB timing, error answers,
  start-to-completion latency and control readback.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ns

module abc_checker
  import abc_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cipher_done_irq
);
  // ------------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------------
  localparam logic [11:0] A_CS = {IDX_CS, 2'b00};
  logic       acc;
  logic       cs_rd;
  logic       start;
  logic       mapped;
  logic       busy;
  logic [6:0] cnt;
  logic [3:0] ctl;

  assign acc    = psel && penable && pready;
  assign cs_rd  = acc && !pwrite && paddr == A_CS;
  assign start  = acc && pwrite && paddr == A_CS && pwdata[0] && !busy;
  assign mapped = paddr[1:0] == 2'b00 && paddr[11:2] inside
                  {IDX_CS, IDX_KEY, IDX_IV, IDX_DATA, IDX_KVPTR, IDX_DPTR};

  // Busy is cleared on the completion pulse, so the counter reads the
  // exact edge number of that pulse counted from the start commit.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      busy <= 1'b0;
      cnt  <= 7'h00;
      ctl  <= 4'h0;
    end else begin
      if (acc && pwrite && paddr == A_CS && !busy) begin
        ctl <= pwdata[4:1];
      end
      if (start) begin
        busy <= 1'b1;
        cnt  <= 7'h01;
      end else if (cipher_done_irq) begin
        busy <= 1'b0;
      end else if (busy) begin
        cnt <= cnt + 7'h01;
      end
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late after access cycle");
  a_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready not a single pulse inside a transfer");
  a_unmapped_err: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (pready && mapped |-> !pslverr && prdata[31:8] == 24'h0)
    else $error("mapped access answered badly");
  a_done_latency: assert property (start |-> ##46 cipher_done_irq)
    else $error("completion pulse late");
  a_irq_timing: assert property (cipher_done_irq |-> busy && cnt == 7'd46)
    else $error("completion pulse early or unrequested");
  a_irq_single: assert property (cipher_done_irq |=> !cipher_done_irq)
    else $error("completion pulse too long");
  a_go_busy: assert property (cs_rd && busy && cnt inside {[3:40]} |-> prdata[0])
    else $error("go bit low while busy");
  a_ctl_readback: assert property (cs_rd && !busy |-> prdata[4:0] == {ctl, 1'b0})
    else $error("control readback wrong when idle");

  cover property (start);
  cover property (cipher_done_irq);
  cover property (pready && pslverr);
  cover property (cs_rd && busy);
endmodule : abc_checker

bind abc_aes_block_coprocessor abc_checker u_chk (
  .ref_clk         (ref_clk),
  .nrst            (nrst),
  .psel            (psel),
  .penable         (penable),
  .pwrite          (pwrite),
  .paddr           (paddr),
  .pwdata          (pwdata),
  .prdata          (prdata),
  .pready          (pready),
  .pslverr         (pslverr),
  .cipher_done_irq (cipher_done_irq)
);

// >>> sim/abc_cpu_model.sv
/*
  Model of the controlling processor as an APB master with one transfer task.
  Assumes a single clock and a slave that answers within sixteen cycles.
*/
`timescale 1ns/1ns

module abc_cpu_model (
  input  wire logic        ref_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
  end

  // Released lines show the inverse value so a stale bus never looks valid.
  task xfer(input logic we, input logic [11:0] a, input logic [7:0] d,
            output logic [31:0] q, output logic err, output logic tmo);
    int i;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= we;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    tmo = 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) begin
        tmo = 1'b0;
        break;
      end
    end
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= ~we;
    paddr   <= ~a;
    pwdata  <= ~{24'h0, d};
  endtask : xfer
endmodule : abc_cpu_model

// >>> sim/aes_block_coprocessor_tb.sv
/*
  Testbench of the block cipher coprocessor: register reset values, pointer
  stepping, all chaining modes against a known key and block, busy writes.
  Assumes the processor model and the bound checker.
*/
`timescale 1ns/1ns

module aes_block_coprocessor_tb
  import abc_pkg::*;
();
  localparam logic [11:0]  A_CS  = {IDX_CS, 2'b00};
  localparam logic [11:0]  A_KEY = {IDX_KEY, 2'b00};
  localparam logic [11:0]  A_IV  = {IDX_IV, 2'b00};
  localparam logic [11:0]  A_DAT = {IDX_DATA, 2'b00};
  localparam logic [11:0]  A_KVP = {IDX_KVPTR, 2'b00};
  localparam logic [11:0]  A_DP  = {IDX_DPTR, 2'b00};
  localparam logic [127:0] KEY   = 128'h000102030405060708090a0b0c0d0e0f;
  localparam logic [127:0] PT    = 128'h00112233445566778899aabbccddeeff;
  localparam logic [127:0] CT    = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
  logic         ref_clk, nrst, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, q;
  logic [127:0] blk;
  int           n_fail, compares, n_irq, i;

  abc_aes_block_coprocessor dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cipher_done_irq(irq));
  abc_cpu_model cpu (.ref_clk(ref_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (irq === 1'b1) n_irq++;
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task tally_and_finish;
    if (n_fail == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  task chk(input string nm, input logic [127:0] ex, input logic [127:0] got);
    compares++;
    if (got !== ex) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask : chk

  task op(input logic we, input logic [11:0] a, input logic [7:0] d);
    logic t;
    cpu.xfer(we, a, d, q, e, t);
    if (t) begin
      n_fail++;
      tally_and_finish();
    end
  endtask : op

  task rdc(input logic [11:0] a, input logic [7:0] ex, input string nm);
    op(1'b0, a, 8'h00);
    chk(nm, ex, q);
  endtask : rdc

  // Pointer 0 holds the last array byte, so the low byte goes first.
  task load(input logic [11:0] a, input logic [127:0] v);
    for (int n = 0; n < 16; n++) op(1'b1, a, v[8*n+:8]);
  endtask : load

  task run(input logic [2:0] m, input logic dec, input logic [127:0] din, input logic poke);
    int w;
    op(1'b1, A_CS, {3'h0, m, dec, 1'b0});
    load(A_DAT, din);
    op(1'b1, A_CS, {3'h0, m, dec, 1'b1});
    if (poke) begin
      op(1'b1, A_DAT, 8'hff);
      rdc(A_DP, 8'h00, "busy data ptr");
    end
    for (w = 0; w < 40; w++) begin
      op(1'b0, A_CS, 8'h00);
      if (q[0] === 1'b0) break;
    end
    if (w == 40) begin
      n_fail++;
      tally_and_finish();
    end
    for (int n = 0; n < 16; n++) begin
      op(1'b0, A_DAT, 8'h00);
      blk[8*n+:8] = q[7:0];
    end
  endtask : run

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    n_fail = 0;
    compares = 0;
    n_irq = 0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    rdc(A_CS, 8'h00, "cs reset");
    rdc(A_KEY, 8'h00, "key reset");
    rdc(A_IV, 8'h00, "iv reset");
    rdc(A_DAT, 8'h00, "data reset");
    rdc(A_KVP, 8'h11, "kv ptr step");
    rdc(A_DP, 8'h01, "data ptr step");
    op(1'b0, 12'h004, 8'h00);
    chk("unmapped err", 1, e);
    op(1'b1, A_KVP, 8'ha5);
    rdc(A_KVP, 8'ha5, "kv ptr");
    op(1'b1, A_DP, 8'h0f);
    op(1'b1, A_DAT, 8'h3c);
    rdc(A_DP, 8'h00, "data ptr wrap");
    op(1'b1, A_DP, 8'h0f);
    rdc(A_DAT, 8'h3c, "single byte");
    op(1'b1, A_KVP, 8'h00);
    op(1'b1, A_DP, 8'h00);
    load(A_KEY, KEY);
    load(A_IV, PT);
    rdc(A_KVP, 8'h00, "kv ptr wrap");
    run(MODE_ECB, 1'b0, PT, 1'b1);
    chk("ecb enc", CT, blk);
    rdc(A_CS, {3'h0, MODE_ECB, 2'b00}, "cs idle");
    run(MODE_ECB, 1'b1, CT, 1'b0);
    chk("ecb dec", PT, blk);
    run(MODE_CBC, 1'b0, 0, 1'b0);
    chk("cbc enc", CT, blk);
    run(MODE_CFB, 1'b0, 0, 1'b0);
    chk("cfb enc", CT, blk);
    run(MODE_OFB, 1'b0, 0, 1'b0);
    chk("ofb enc", CT, blk);
    run(MODE_CTR, 1'b0, 0, 1'b0);
    chk("ctr first", CT, blk);
    load(A_IV, PT);
    run(MODE_CTR, 1'b0, 0, 1'b0);
    compares++;
    if (blk === CT) begin
      n_fail++;
      $display("BAD ctr step exp not %h got %h", CT, blk);
    end
    run(MODE_ECB, 1'b0, PT, 1'b0);
    run(MODE_CTR, 1'b0, 0, 1'b0);
    chk("ctr reload", CT, blk);
    run(MODE_CFB, 1'b1, 0, 1'b0);
    chk("cfb dec", CT, blk);
    run(MODE_OFB, 1'b1, 0, 1'b0);
    chk("ofb dec", CT, blk);
    run(MODE_CBC, 1'b1, CT, 1'b0);
    chk("cbc dec", 0, blk);
    chk("irq count", 12, n_irq);
    tally_and_finish();
  end
endmodule : aes_block_coprocessor_tb
